// ---- pkg/csc_defs.vh ----
// Purpose: Constants for the channel scan configuration block.
// Assumes: Word-aligned byte offsets on an 8-bit register address.
// Notes: Include once; guarded against double inclusion.
`ifndef CSC_DEFS_VH
`define CSC_DEFS_VH

// ****************************************************************
// Register byte offsets.
// ****************************************************************
`define CSC_REG_CFG_FIRST 8'h00
`define CSC_REG_CFG_LAST 8'h04
`define CSC_REG_CFG_TYPE 8'h08
`define CSC_REG_CFG_HI 8'h0C
`define CSC_REG_CFG_LO 8'h10
`define CSC_REG_CFG_HYST 8'h14
`define CSC_REG_CTRL 8'h18
`define CSC_REG_IRQ_STAT 8'h1C
`define CSC_REG_IRQ_CLR 8'h20
`define CSC_REG_IRQ_EN 8'h24
`define CSC_REG_SLOTS 8'h28
`define CSC_REG_CH_SEL 8'h2C
`define CSC_REG_CH_INFO 8'h30

// ****************************************************************
// Field positions.
// ****************************************************************
`define CSC_CTRL_GO 0
`define CSC_CTRL_SCAN 1
`define CSC_CTRL_CONT 2
`define CSC_TYPE_NOCHK 8
`define CSC_TYPE_ALEN 9
`define CSC_ST_CFG_ERR 0
`define CSC_ST_BUSY_REJ 1
`define CSC_ST_ALARM 2
`define CSC_ST_SCAN_DONE 3

// ****************************************************************
// Module kinds seen in a slot and transducer type codes.
// ****************************************************************
`define CSC_KIND_NONE 2'h0
`define CSC_KIND_TC 2'h1
`define CSC_KIND_LV 2'h2
`define CSC_KIND_HV 2'h3
`define CSC_T_TC_LO 6'h01
`define CSC_T_TC_HI 6'h09
`define CSC_T_LVDC_LO 6'h0B
`define CSC_T_LVDC_HI 6'h0E
`define CSC_T_LVAC_LO 6'h17
`define CSC_T_LVAC_HI 6'h1A
`define CSC_T_HVDC_LO 6'h14
`define CSC_T_HVDC_HI 6'h16
`define CSC_T_HVAC_LO 6'h1C
`define CSC_T_HVAC_HI 6'h1E

// ****************************************************************
// Reset values.
// ****************************************************************
`define CSC_RST_WORD 32'h0000_0000
`define CSC_RST_IRQ_EN 4'h0

`endif

// ---- logic/csc_top.v ----
// Purpose: Channel table, configure command checker and ascending scanner.
// Assumes: Converter and trigger logic share this clock.
// Notes: Slot kind pins are synchronised before use.
//
// Contract
// - Up to 128 channels, eight modules of 16.
// - Detect module kind in all eight slots.
// - Bad channel or type logs configuration error.
// - Thermocouple codes 1 to 9 decoded.
// - Low-volt codes 11-14 DC, 23-26 AC.
// - High-volt codes 20-22 DC, 28-30 AC.
// - Reject configuration while armed or acquiring.
// - Store alarm high, low and hysteresis.
// - Raise alarm event when value leaves limits.
// - Scan only configured channels, skip others.
// - Scan always in ascending channel order.
// - One scan configuration for both consumers.
// - No random channel selection within scans.
// - Convert raw voltage by type before return.
// - Configure single channels or ranges, any order.
// - Thermocouple modules accept low-volt DC types too.
`timescale 1ns/1ps
`include "csc_defs.vh"

module csc_top #(
    parameter NCH = 128,
    parameter DW = 16
) (
    input wire clock,
    input wire arst_n,
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata_ff,
    input wire [15:0] slot_kind_pin,
    input wire trig_armed,
    input wire acq_active,
    output reg scan_req_ff,
    output reg [6:0] scan_chan_ff,
    output reg [5:0] scan_type_ff,
    input wire raw_valid,
    input wire [DW-1:0] raw_data,
    output reg data_valid_ff,
    output reg [6:0] data_chan_ff,
    output reg [DW-1:0] data_value_ff,
    output reg data_ovr_ff,
    output reg alarm_evt_ff,
    output reg alarm_any_ff,
    output reg irq_ff
);

    // ****************************************************************
    // State codes.
    // ****************************************************************
    localparam [2:0] CF_IDLE = 3'h1; // Waiting for a go command.
    localparam [2:0] CF_CHECK = 3'h2; // Validating every channel first.
    localparam [2:0] CF_WRITE = 3'h4; // Committing the checked range.
    localparam [2:0] SC_IDLE = 3'h1; // Scanner stopped.
    localparam [2:0] SC_SEEK = 3'h2; // Looking for next configured one.
    localparam [2:0] SC_WAIT = 3'h4; // Waiting for the raw sample.
    localparam [6:0] LAST_CH = 7'h7F; // Highest channel number.

    // ****************************************************************
    // Storage and state.
    // ****************************************************************
    reg [15:0] sync1_ff; // First synchroniser stage of slot pins.
    reg [15:0] slot_ff; // Stable slot kinds, two bits per slot.
    reg [7:0] first_ff, last_ff; // Channel range of the pending request.
    reg [9:0] ctype_ff; // Pending type, range-check and alarm flags.
    reg [DW-1:0] chi_ff, clo_ff, chy_ff; // Pending alarm high, low, hysteresis.
    reg cont_ff; // Scanner restarts after the last channel.
    reg [3:0] stat_ff; // Sticky event bits.
    reg [3:0] en_ff; // Interrupt enables.
    reg [6:0] sel_ff; // Channel chosen for table read-back.
    reg [2:0] cf_ff; // Configure state.
    reg [6:0] cptr_ff; // Configure walk pointer.
    reg [2:0] sc_ff; // Scanner state.
    reg [6:0] sptr_ff; // Scanner pointer, only ever counts up.
    reg [NCH-1:0] cfgd_ff; // Channel is in the scan list.
    reg [NCH-1:0] alarm_ff; // Channel is currently out of limits.
    reg [5:0] typ_mem [0:NCH-1]; // Type code per channel.
    reg [1:0] flg_mem [0:NCH-1]; // No-range-check and alarm enable.
    // Alarm high, low and hysteresis levels of every channel.
    reg [DW-1:0] hi_mem [0:NCH-1], lo_mem [0:NCH-1], hy_mem [0:NCH-1];
    // Decoded bus strokes.
    wire wr_ctrl = reg_wr && (reg_addr == `CSC_REG_CTRL);
    wire go_cmd = wr_ctrl && reg_wdata[`CSC_CTRL_GO];
    wire scan_cmd = wr_ctrl && reg_wdata[`CSC_CTRL_SCAN];

    // ****************************************************************
    // Type decoding helpers.
    // ****************************************************************
    // Tells whether a type code may be used on a given module kind.
    function type_ok;
        input [1:0] kind;
        input [5:0] t;
        reg tc, lvdc, lvac, hvdc, hvac;
        begin
            tc = (t >= `CSC_T_TC_LO) && (t <= `CSC_T_TC_HI);
            lvdc = (t >= `CSC_T_LVDC_LO) && (t <= `CSC_T_LVDC_HI);
            lvac = (t >= `CSC_T_LVAC_LO) && (t <= `CSC_T_LVAC_HI);
            hvdc = (t >= `CSC_T_HVDC_LO) && (t <= `CSC_T_HVDC_HI);
            hvac = (t >= `CSC_T_HVAC_LO) && (t <= `CSC_T_HVAC_HI);
            case (kind)
                `CSC_KIND_TC: type_ok = tc || lvdc;
                `CSC_KIND_LV: type_ok = lvdc || lvac;
                `CSC_KIND_HV: type_ok = hvdc || hvac;
                default: type_ok = 1'b0;
            endcase
        end
    endfunction
    // Gives the scale shift of a type; all voltage codes share one rule.
    function [1:0] type_shift;
        input [5:0] t;
        begin
            if (t >= `CSC_T_LVDC_LO) begin
                type_shift = 2'h2 - t[1:0];
            end else begin
                type_shift = 2'h0;
            end
        end
    endfunction

    // ****************************************************************
    // Slot detection.
    // ****************************************************************
    // The kind pins come from the module backplane, so they are
    // synchronised twice; slot n of a channel is its bits 6 to 4.
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sync1_ff <= 16'h0000;
            slot_ff <= 16'h0000;
        end else begin
            sync1_ff <= slot_kind_pin;
            slot_ff <= sync1_ff;
        end
    end
    // Kind of the module that holds the channel under check.
    wire [1:0] ckind = slot_ff[{cptr_ff[6:4], 1'b0} +: 2];
    wire cbad = ctype_ff[5:0] != 6'h00 && !type_ok(ckind, ctype_ff[5:0]);
    wire range_bad = (first_ff > last_ff) || last_ff[7];
    wire cfg_busy = trig_armed || acq_active;

    // ****************************************************************
    // Configure command sequencer.
    // ****************************************************************
    // Two passes over the range: every channel is checked before any
    // is written, so an error never leaves a half-applied request.
    reg [2:0] nxt_cf;
    reg cf_err, cf_rej; // Range or type error; refusal while busy.
    always @* begin
        nxt_cf = cf_ff;
        cf_err = 1'b0;
        cf_rej = 1'b0;
        case (cf_ff)
            CF_IDLE: begin
                if (go_cmd && cfg_busy) begin
                    cf_rej = 1'b1;
                end else if (go_cmd && range_bad) begin
                    cf_err = 1'b1;
                end else if (go_cmd) begin
                    nxt_cf = CF_CHECK;
                end
            end
            CF_CHECK: begin
                if (cbad) begin
                    cf_err = 1'b1;
                    nxt_cf = CF_IDLE;
                end else if (cptr_ff == last_ff[6:0]) begin
                    nxt_cf = CF_WRITE;
                end
            end
            CF_WRITE: begin
                if (cptr_ff == last_ff[6:0]) begin
                    nxt_cf = CF_IDLE;
                end
            end
            default: nxt_cf = CF_IDLE;
        endcase
    end
    // Pointer and state of the sequencer.
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cf_ff <= CF_IDLE;
            cptr_ff <= 7'h00;
        end else begin
            cf_ff <= nxt_cf;
            cptr_ff <= (cf_ff == CF_IDLE || nxt_cf != cf_ff) ?
                       first_ff[6:0] : cptr_ff + 7'h01;
        end
    end
    // Table writes; the array holds no reset, the valid bits do.
    always @(posedge clock) begin
        if (cf_ff == CF_WRITE) begin
            typ_mem[cptr_ff] <= ctype_ff[5:0];
            flg_mem[cptr_ff] <= ctype_ff[9:8];
            hi_mem[cptr_ff] <= chi_ff;
            lo_mem[cptr_ff] <= clo_ff;
            hy_mem[cptr_ff] <= chy_ff;
        end
    end

    // ****************************************************************
    // Scanner.
    // ****************************************************************
    // The pointer only steps upward from zero, and nothing lets the
    // host pick a single channel; data leaves in scan order only.
    wire [5:0] styp = typ_mem[sptr_ff];
    wire [1:0] sflg = flg_mem[sptr_ff];
    wire signed [DW-1:0] raw_s = raw_data;
    wire signed [DW-1:0] conv = raw_s <<< type_shift(styp);
    wire sat = (raw_data == {1'b0, {(DW-1){1'b1}}}) ||
               (raw_data == {1'b1, {(DW-1){1'b0}}});
    wire signed [DW:0] hi_s = {hi_mem[sptr_ff][DW-1], hi_mem[sptr_ff]};
    wire signed [DW:0] lo_s = {lo_mem[sptr_ff][DW-1], lo_mem[sptr_ff]};
    wire signed [DW:0] hy_s = {1'b0, hy_mem[sptr_ff]};
    wire signed [DW:0] cv_s = {conv[DW-1], conv};
    wire out_lim = (cv_s > hi_s) || (cv_s < lo_s);
    wire back_in = (cv_s <= hi_s - hy_s) && (cv_s >= lo_s + hy_s);
    wire take = (sc_ff == SC_WAIT) && raw_valid;
    wire at_end = (sptr_ff == LAST_CH);
    wire al_new = take && sflg[1] && out_lim && !alarm_ff[sptr_ff];
    wire sc_done = ((sc_ff == SC_SEEK) && !cfgd_ff[sptr_ff] && at_end) ||
                   (take && at_end);
    // Scanner state, pointer and the request toward the converter.
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sc_ff <= SC_IDLE;
            sptr_ff <= 7'h00;
            scan_req_ff <= 1'b0;
            scan_chan_ff <= 7'h00;
            scan_type_ff <= 6'h00;
        end else begin
            scan_req_ff <= 1'b0;
            case (sc_ff)
                SC_IDLE: begin
                    sptr_ff <= 7'h00;
                    if (scan_cmd) begin
                        sc_ff <= SC_SEEK;
                    end
                end
                SC_SEEK: begin
                    if (cfgd_ff[sptr_ff]) begin
                        scan_req_ff <= 1'b1;
                        scan_chan_ff <= sptr_ff;
                        scan_type_ff <= styp;
                        sc_ff <= SC_WAIT;
                    end else if (at_end) begin
                        sc_ff <= cont_ff ? SC_SEEK : SC_IDLE;
                        sptr_ff <= 7'h00;
                    end else begin
                        sptr_ff <= sptr_ff + 7'h01;
                    end
                end
                SC_WAIT: begin
                    if (raw_valid) begin
                        sc_ff <= (at_end && !cont_ff) ? SC_IDLE : SC_SEEK;
                        sptr_ff <= sptr_ff + 7'h01;
                    end
                end
                default: sc_ff <= SC_IDLE;
            endcase
        end
    end
    // One result stream feeds both the last-value registers and the
    // acquisition buffer, so both see the same scan list.
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            data_valid_ff <= 1'b0;
            data_chan_ff <= 7'h00;
            data_value_ff <= {DW{1'b0}};
            data_ovr_ff <= 1'b0;
            alarm_evt_ff <= 1'b0;
            alarm_any_ff <= 1'b0;
        end else begin
            data_valid_ff <= take;
            alarm_evt_ff <= al_new;
            alarm_any_ff <= |alarm_ff;
            if (take) begin
                data_chan_ff <= sptr_ff;
                data_value_ff <= conv;
                data_ovr_ff <= sat && !sflg[0];
            end
        end
    end
    // ****************************************************************
    // Per-channel valid and alarm bits.
    // ****************************************************************
    // Each channel joins the scan list when written with a non-zero
    // type; the alarm bit holds until the value is back by the
    // hysteresis, which stops chatter at the limit.
    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1) begin : g_ch
            always @(posedge clock or negedge arst_n) begin
                if (!arst_n) begin
                    cfgd_ff[g] <= 1'b0;
                    alarm_ff[g] <= 1'b0;
                end else begin
                    if (cf_ff == CF_WRITE && cptr_ff == g) begin
                        cfgd_ff[g] <= (ctype_ff[5:0] != 6'h00);
                        alarm_ff[g] <= 1'b0;
                    end else if (take && sptr_ff == g) begin
                        if (sflg[1] && out_lim) begin
                            alarm_ff[g] <= 1'b1;
                        end else if (!sflg[1] || back_in) begin
                            alarm_ff[g] <= 1'b0;
                        end
                    end
                end
            end
        end
    endgenerate
    // ****************************************************************
    // Register writes and event bits.
    // ****************************************************************
    // An event in the same cycle as its clear wins over the clear.
    wire [3:0] ev = {sc_done, al_new, cf_rej, cf_err};
    wire [3:0] clr = (reg_wr && reg_addr == `CSC_REG_IRQ_CLR) ?
                     reg_wdata[3:0] : 4'h0;
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            first_ff <= 8'h00;
            last_ff <= 8'h00;
            ctype_ff <= 10'h000;
            chi_ff <= {DW{1'b0}};
            clo_ff <= {DW{1'b0}};
            chy_ff <= {DW{1'b0}};
            cont_ff <= 1'b0;
            stat_ff <= 4'h0;
            en_ff <= `CSC_RST_IRQ_EN;
            sel_ff <= 7'h00;
            irq_ff <= 1'b0;
        end else begin
            stat_ff <= (stat_ff & ~clr) | ev;
            irq_ff <= |(stat_ff & en_ff);
            // Pending request fields are frozen while a walk runs.
            if (reg_wr && cf_ff == CF_IDLE) begin
                case (reg_addr)
                    `CSC_REG_CFG_FIRST: first_ff <= reg_wdata[7:0];
                    `CSC_REG_CFG_LAST: last_ff <= reg_wdata[7:0];
                    `CSC_REG_CFG_TYPE: ctype_ff <= reg_wdata[9:0];
                    `CSC_REG_CFG_HI: chi_ff <= reg_wdata[DW-1:0];
                    `CSC_REG_CFG_LO: clo_ff <= reg_wdata[DW-1:0];
                    `CSC_REG_CFG_HYST: chy_ff <= reg_wdata[DW-1:0];
                    default: ;
                endcase
            end
            if (reg_wr) begin
                case (reg_addr)
                    `CSC_REG_CTRL: cont_ff <= reg_wdata[`CSC_CTRL_CONT];
                    `CSC_REG_IRQ_EN: en_ff <= reg_wdata[3:0];
                    `CSC_REG_CH_SEL: sel_ff <= reg_wdata[6:0];
                    default: ;
                endcase
            end
        end
    end
    // ****************************************************************
    // Register reads.
    // ****************************************************************
    // Read data stands only in the cycle after the strobe; unmapped
    // and write-only addresses read as zero.
    reg [31:0] nxt_rdata;
    always @* begin
        nxt_rdata = `CSC_RST_WORD;
        case (reg_addr)
            `CSC_REG_CFG_FIRST: nxt_rdata = {24'h000000, first_ff};
            `CSC_REG_CFG_LAST: nxt_rdata = {24'h000000, last_ff};
            `CSC_REG_CFG_TYPE: nxt_rdata = {22'h000000, ctype_ff};
            `CSC_REG_CFG_HI: nxt_rdata[DW-1:0] = chi_ff;
            `CSC_REG_CFG_LO: nxt_rdata[DW-1:0] = clo_ff;
            `CSC_REG_CFG_HYST: nxt_rdata[DW-1:0] = chy_ff;
            `CSC_REG_CTRL: nxt_rdata = {26'h0000000, cf_ff != CF_IDLE,
                                        sc_ff != SC_IDLE, 1'b0, cont_ff, 2'h0};
            `CSC_REG_IRQ_STAT: nxt_rdata = {28'h0000000, stat_ff};
            `CSC_REG_IRQ_EN: nxt_rdata = {28'h0000000, en_ff};
            `CSC_REG_SLOTS: nxt_rdata = {16'h0000, slot_ff};
            `CSC_REG_CH_SEL: nxt_rdata = {25'h0000000, sel_ff};
            `CSC_REG_CH_INFO: nxt_rdata = {16'h0000, alarm_ff[sel_ff],
                                           cfgd_ff[sel_ff], 4'h0,
                                           flg_mem[sel_ff], 2'h0,
                                           typ_mem[sel_ff]};
            default: nxt_rdata = `CSC_RST_WORD;
        endcase
    end
    // Registered read port.
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata_ff <= `CSC_RST_WORD;
        end else begin
            reg_rdata_ff <= reg_rd ? nxt_rdata : `CSC_RST_WORD;
        end
    end
endmodule // csc_top

// ---- dv/csc_chk_sva.sv ----
// Purpose: Port checks for the scan configuration block.
// Assumes: One clock, reset asynchronous and active low.
// Notes: Bound from the testbench top file.
`timescale 1ns/1ps
`include "csc_defs.vh"
module csc_chk (
    input wire clock,
    input wire arst_n,
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [31:0] reg_rdata_ff,
    input wire scan_req_ff,
    input wire [6:0] scan_chan_ff,
    input wire raw_valid,
    input wire data_valid_ff,
    input wire [6:0] data_chan_ff,
    input wire alarm_evt_ff,
    input wire alarm_any_ff,
    input wire irq_ff
);
    // ************************************************************
    // Assertions.
    // ************************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);
    // A request must be followed by two cycles without a request.
    sequence s_quiet;
        !scan_req_ff ##1 !scan_req_ff;
    endsequence
    AST_RDATA_IDLE:
        assert property (!reg_rd |=> reg_rdata_ff == 32'h0)
        else $error("Read data not zero outside a read.");
    AST_RAW_TO_DATA:
        assert property (data_valid_ff |-> $past(raw_valid))
        else $error("Sample out without a raw sample.");
    AST_DATA_CHAN:
        assert property (data_valid_ff |-> data_chan_ff == scan_chan_ff)
        else $error("Sample channel differs from request.");
    AST_REQ_GAP:
        assert property (scan_req_ff |=> s_quiet)
        else $error("Request repeated too soon.");
    AST_DATA_WAITS:
        assert property (scan_req_ff |=> !data_valid_ff)
        else $error("Sample out in the cycle after request.");
    AST_ALARM_SRC:
        assert property (alarm_evt_ff |-> data_valid_ff
            || $past(data_valid_ff) || $past(data_valid_ff, 2))
        else $error("Alarm event without a sample.");
    AST_ALARM_LEVEL:
        assert property (alarm_evt_ff |-> ##[0:2] alarm_any_ff)
        else $error("Alarm level missing after event.");
    AST_IRQ_MASK:
        assert property (reg_wr && reg_addr == `CSC_REG_IRQ_EN
            && reg_wdata[3:0] == 4'h0 |=> ##1 !irq_ff)
        else $error("Interrupt high with all enables off.");
endmodule // csc_chk

// ---- dv/csc_raw_src.sv ----
// Purpose: Converter model answering raw sample requests.
// Assumes: Channel number holds from request to answer.
// Notes: Latency is two to five cycles, set by the channel.
`timescale 1ns/1ps
module csc_raw_src (
    input wire clock,
    input wire arst_n,
    input wire req,
    input wire [6:0] chan,
    output reg raw_valid,
    output reg [15:0] raw_data
);
    reg [2:0] wait_ff; // Cycles left until the sample is handed over.
    // Idle data toggles so a stale word never looks like a sample.
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            wait_ff <= 3'h0;
            raw_valid <= 1'b0;
            raw_data <= 16'h5A5A;
        end else begin
            raw_valid <= wait_ff == 3'h1;
            raw_data <= wait_ff == 3'h1 ? {1'b0, chan, 8'h21} : ~raw_data;
            if (req) begin
                wait_ff <= {1'b0, chan[1:0]} + 3'h1;
            end else if (wait_ff != 3'h0) begin
                wait_ff <= wait_ff - 3'h1;
            end
        end
    end
endmodule // csc_raw_src

// ---- dv/channel_scan_config_test.sv ----
// Purpose: Self-checking bench for the scan configuration block.
// Assumes: Slots 0 to 3 hold thermo, low volt, high volt, nothing.
// Notes: Channel picks are random from a fixed seed.
`timescale 1ns/1ps
`include "csc_defs.vh"
module channel_scan_config_test;
    reg clock, arst_n, reg_wr, reg_rd, trig_armed, acq_active, rd_seen;
    reg [7:0] reg_addr;
    reg [31:0] reg_wdata;
    reg [15:0] slot_kind_pin;
    wire [31:0] reg_rdata_ff;
    wire scan_req_ff, raw_valid, data_valid_ff, alarm_evt_ff, irq_ff;
    wire alarm_any_ff;
    wire [6:0] scan_chan_ff, data_chan_ff;
    wire [15:0] raw_data, data_value_ff;
    integer n_mismatch, checked, seed, k, t, ch;
    reg [31:0] info [0:127]; // Expected info word of each channel.
    reg [31:0] rq[$]; // Expected read data, oldest first.
    reg [22:0] dq[$]; // Expected channel and value of each sample.
    csc_top #(.NCH(128), .DW(16)) dut (.clock(clock), .arst_n(arst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
        .slot_kind_pin(slot_kind_pin), .trig_armed(trig_armed),
        .acq_active(acq_active), .scan_req_ff(scan_req_ff),
        .scan_chan_ff(scan_chan_ff), .scan_type_ff(), .raw_valid(raw_valid),
        .raw_data(raw_data), .data_valid_ff(data_valid_ff),
        .data_chan_ff(data_chan_ff), .data_value_ff(data_value_ff),
        .data_ovr_ff(), .alarm_evt_ff(alarm_evt_ff),
        .alarm_any_ff(alarm_any_ff), .irq_ff(irq_ff));
    csc_raw_src u_src (.clock(clock), .arst_n(arst_n), .req(scan_req_ff),
        .chan(scan_chan_ff), .raw_valid(raw_valid), .raw_data(raw_data));
    task check(input string what, input [31:0] seen, input [31:0] exp);
        checked = checked + 1;
        if (seen !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("Error %0s expected %h seen %h", what, exp, seen);
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task rd(input [7:0] a, input [31:0] exp);
        rq.push_back(exp);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
    endtask
    // Loads a range and type, issues go, then lets the walk finish.
    task cfg(input [7:0] f, input [7:0] l, input [31:0] tw, input integer n);
        wr(`CSC_REG_CFG_FIRST, f);
        wr(`CSC_REG_CFG_LAST, l);
        wr(`CSC_REG_CFG_TYPE, tw);
        wr(`CSC_REG_CTRL, 32'h1);
        repeat (n) @(posedge clock);
    endtask
    function legal(input [1:0] kind, input [5:0] c);
        reg lv;
        lv = c >= 6'h0B && c <= 6'h0E;
        case (kind)
            2'h1: legal = c <= 6'h09 || lv;
            2'h2: legal = lv || (c >= 6'h17 && c <= 6'h1A);
            2'h3: legal = (c >= 6'h14 && c <= 6'h16) ||
                (c >= 6'h1C && c <= 6'h1E);
            default: legal = 1'b0;
        endcase
    endfunction
    // Voltage codes are scaled by a shift, thermocouple codes are not.
    function [22:0] smp(input [6:0] c, input [5:0] ty);
        smp = {c, ty <= 6'h09 ? {1'b0, c, 8'h21}
            : {1'b0, c, 8'h21} << ((6'h02 - ty) & 6'h03)};
    endfunction
    task give_verdict;
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    // Tests need about 3500 cycles; allow far more before giving up.
    initial begin
        repeat (30000) @(posedge clock);
        n_mismatch = n_mismatch + 1;
        give_verdict;
    end
    // Each note is matched against the result when it appears.
    always @(posedge clock) begin
        if (rd_seen) check("read", reg_rdata_ff, rq.pop_front());
        if (data_valid_ff) check("sample", {data_chan_ff, data_value_ff}, dq.pop_front());
        rd_seen <= reg_rd;
    end
    initial begin
        {seed, n_mismatch, checked} = {32'h08FA, 64'h0};
        {arst_n, reg_wr, reg_rd, rd_seen, trig_armed, acq_active} = 6'h0;
        {reg_addr, reg_wdata} = 40'h0;
        slot_kind_pin = 16'h0039;
        for (ch = 0; ch < 128; ch = ch + 1) info[ch] = 32'h0;
        repeat (10) @(posedge clock);
        arst_n <= 1'b1;
        cfg(8'h00, 8'h7F, 32'h0, 300);
        // Codes 1 to 31 on each slot kind; a refusal keeps the old entry.
        for (k = 0; k < 4; k = k + 1) for (t = 1; t < 32; t = t + 1) begin
            ch = k * 16 + ($random(seed) & 15);
            cfg(ch, ch, t, 4);
            rd(`CSC_REG_IRQ_STAT, !legal(k + 1, t));
            wr(`CSC_REG_IRQ_CLR, 32'hF);
            if (legal(k + 1, t)) info[ch] = 32'h4000 | t;
            wr(`CSC_REG_CH_SEL, ch);
            rd(`CSC_REG_CH_INFO, info[ch]);
        end
        wr(`CSC_REG_CH_SEL, 8'h10);
        for (k = 0; k < 2; k = k + 1) begin
            trig_armed <= k == 0;
            acq_active <= k == 1;
            cfg(8'h10, 8'h10, 32'h0C, 4);
            rd(`CSC_REG_IRQ_STAT, 32'h2);
            rd(`CSC_REG_CH_INFO, info[16]);
            wr(`CSC_REG_IRQ_CLR, 32'hF);
        end
        {trig_armed, acq_active} <= 2'h0;
        cfg(8'h05, 8'h80, 32'h1, 4); // Channel 128 does not exist.
        rd(`CSC_REG_IRQ_STAT, 32'h1);
        wr(`CSC_REG_IRQ_CLR, 32'hF);
        cfg(8'h00, 8'h7F, 32'h0, 300);
        cfg(8'h11, 8'h11, 32'h0C, 6); // Higher channel given first.
        wr(`CSC_REG_CFG_HI, 32'h0300);
        wr(`CSC_REG_CFG_LO, 32'h8000);
        wr(`CSC_REG_CFG_HYST, 32'h0);
        cfg(8'h02, 8'h04, 32'h201, 10); // Alarm enabled on 2 to 4.
        for (k = 2; k < 5; k = k + 1) dq.push_back(smp(k, 6'h01));
        dq.push_back(smp(7'h11, 6'h0C));
        wr(`CSC_REG_IRQ_CLR, 32'hF);
        wr(`CSC_REG_CTRL, 32'h2);
        repeat (250) @(posedge clock);
        check("left", dq.size(), 0);
        rd(`CSC_REG_IRQ_STAT, 32'hC);
        wr(`CSC_REG_IRQ_EN, 32'h4);
        repeat (3) @(posedge clock);
        check("irq", irq_ff, 1'b1);
        wr(`CSC_REG_IRQ_EN, 32'h0);
        wr(`CSC_REG_IRQ_CLR, 32'hF);
        rd(8'hFC, 32'h0);
        repeat (3) @(posedge clock);
        check("irq", irq_ff, 1'b0);
        give_verdict;
    end
endmodule // channel_scan_config_test
bind csc_top csc_chk u_chk (.clock(clock), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .irq_ff(irq_ff),
    .scan_req_ff(scan_req_ff), .scan_chan_ff(scan_chan_ff),
    .raw_valid(raw_valid), .data_valid_ff(data_valid_ff),
    .data_chan_ff(data_chan_ff), .alarm_evt_ff(alarm_evt_ff),
    .alarm_any_ff(alarm_any_ff));
